// [common/asr_defs.svh]
// Purpose: Offsets, reset values and field positions for sample ready block
// Assumes: Byte-wide register port on sys_clk, one access per cycle
// Notes:   Included by name; definitions only
// Function
// (R1) Set ready flag on new sample
// (R2) Reading sample data clears ready flag
// (R3) Sample during read sets flag until next
// (R4) Pending newer sample supplied, cleared at start
// (R5) Overtaken sample dropped without any error
// (R6) Read done, nothing pending: flag zero
// (R7) Select bit routes flag to serial out
// (R8) Map bits route flag to interrupts
// (R9) Low-res modes zero four result LSBs
// (R10) Axis words split high/low at 0x15..
// (R11) Count weight follows range setting
// (R12) Read spans first to last byte, coherent
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH
`define ASR_OFS_STATUS  8'h14
`define ASR_OFS_XH      8'h15
`define ASR_OFS_XL      8'h16
`define ASR_OFS_YH      8'h17
`define ASR_OFS_YL      8'h18
`define ASR_OFS_ZH      8'h19
`define ASR_OFS_ZL      8'h1A
`define ASR_RST_BYTE    8'h00
`define ASR_RST_WORD    16'h0000
`define ASR_LOWRES_MASK 16'hFFF0
`define ASR_READY_BIT   0
`endif

// [common/asr_pkg.sv]
// Purpose: Types for the sample ready block
// Assumes: Nothing beyond the defs header
// Notes:   Power modes named from what they do
package asr_pkg;
    typedef enum logic [2:0] {
        asr_mode_high_perf,
        asr_mode_low_power,
        asr_mode_very_low_power_mode,
        asr_mode_ultra_low_power_mode,
        asr_mode_high_speed_mode
    } asr_mode_t;
    typedef enum logic {
        asr_idle,
        asr_reading
    } asr_rd_state_t;
endpackage : asr_pkg

// [verilog/asr_range_scale.sv]
// Purpose: Range scaling and low-resolution masking of one axis result
// Assumes: Raw result is signed 16-bit at the narrowest range weight
// Notes:   Combinational; registered by the caller
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_range_scale #(
    parameter int WIDTH = 16                  // Result width
) (
    input  wire logic [WIDTH-1:0] raw,        // Raw converter result
    input  wire logic [1:0]       range_sel,  // Range: 0 narrow .. 2 wide
    input  wire logic             low_res,    // 12-bit converter in use
    output logic      [WIDTH-1:0] scaled      // Scaled, masked result
);
    logic [WIDTH-1:0] shifted;                // Result after range shift

    // Wider range makes each count weigh more: arithmetic shift right
    always_comb begin
        case (range_sel)
            2'h1:    shifted = WIDTH'($signed(raw) >>> 1);   // R11
            2'h2:    shifted = WIDTH'($signed(raw) >>> 2);   // R11
            default: shifted = raw;
        endcase
        // Four LSBs forced to zero in low-resolution modes
        scaled = low_res ? (shifted & `ASR_LOWRES_MASK) : shifted; // R9
    end
endmodule : asr_range_scale

// [verilog/asr_sample_ready.sv]
// Purpose: Axis output registers and clear-on-read sample ready flag
// Assumes: Host reads one register per cycle via rd_en/rd_addr
// Notes:   A read session spans the first to the last axis byte
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_sample_ready (
    input  wire logic             sys_clk,      // 200 MHz clock
    input  wire logic             rstn,         // Async reset, active low
    input  wire logic             new_valid,    // New sample strobe
    input  wire logic [15:0]      new_x,        // Raw X result
    input  wire logic [15:0]      new_y,        // Raw Y result
    input  wire logic [15:0]      new_z,        // Raw Z result
    input  wire asr_pkg::asr_mode_t power_mode, // Converter power mode
    input  wire logic [1:0]       range_sel,    // Measurement range
    input  wire logic             rd_en,        // Register read strobe
    input  wire logic [7:0]       rd_addr,      // Register read address
    input  wire logic             ready_on_serial_out_select, // Flag to pin
    input  wire logic             ready_to_irq0_map, // Flag to irq 0
    input  wire logic             ready_to_irq1_map, // Flag to irq 1
    output logic      [7:0]       rd_data,      // Read data, registered
    output logic                  serial_out_pin, // Serial out, flag route
    output logic                  interrupt_out_0, // Interrupt 0
    output logic                  interrupt_out_1  // Interrupt 1
);
    ////////////////////////////////////////////////////////////////////////
    // Scaling of incoming samples
    ////////////////////////////////////////////////////////////////////////
    logic        low_res;                   // 12-bit converter mode
    logic [15:0] raw_ax [3];                // Raw X, Y, Z by axis index
    logic [15:0] sc_ax  [3];                // Scaled X, Y, Z by axis index
    logic [15:0] sc_x;                      // Scaled X
    logic [15:0] sc_y;                      // Scaled Y
    logic [15:0] sc_z;                      // Scaled Z

    // Three power modes use the coarse converter
    assign low_res =
        (power_mode == asr_pkg::asr_mode_very_low_power_mode) ||
        (power_mode == asr_pkg::asr_mode_ultra_low_power_mode) ||
        (power_mode == asr_pkg::asr_mode_high_speed_mode);   // R9

    // Gather the axes so one loop builds every scaler
    assign raw_ax[0] = new_x;
    assign raw_ax[1] = new_y;
    assign raw_ax[2] = new_z;

    // One scaler per axis; all share range and resolution settings
    for (genvar a = 0; a < 3; a++) begin : g_axis
        asr_range_scale #(
            .WIDTH(16)
        ) u_scale (
            .raw       (raw_ax[a]),
            .range_sel (range_sel),
            .low_res   (low_res),
            .scaled    (sc_ax[a])
        );
    end

    assign sc_x = sc_ax[0];
    assign sc_y = sc_ax[1];
    assign sc_z = sc_ax[2];

    ////////////////////////////////////////////////////////////////////////
    // Sample state: pending sample, visible sample, flag
    ////////////////////////////////////////////////////////////////////////
    asr_pkg::asr_rd_state_t state;          // Read session state
    asr_pkg::asr_rd_state_t next_state;
    logic [15:0] pend_x, pend_y, pend_z;    // Newest sample, not yet shown
    logic [15:0] next_pend_x, next_pend_y, next_pend_z;
    logic        pend_vld;                  // Pending sample waiting
    logic        next_pend_vld;
    logic [15:0] shw_x, shw_y, shw_z;       // Sample frozen for the host
    logic [15:0] next_shw_x, next_shw_y, next_shw_z;
    logic        ready;                     // Sample ready flag
    logic        next_ready;
    logic        axis_hit;                  // Read hits an axis byte
    logic        last_hit;                  // Read hits the last byte

    assign axis_hit = rd_en && (rd_addr >= `ASR_OFS_XH) &&
                      (rd_addr <= `ASR_OFS_ZL);                // R12
    assign last_hit = rd_en && (rd_addr == `ASR_OFS_ZL);       // R12

    // Next-state logic; a new sample always wins over any clear
    always_comb begin
        next_state  = state;
        next_pend_x = pend_x;
        next_pend_y = pend_y;
        next_pend_z = pend_z;
        next_pend_vld = pend_vld;
        next_shw_x  = shw_x;
        next_shw_y  = shw_y;
        next_shw_z  = shw_z;
        next_ready  = ready;
        case (state)
            asr_pkg::asr_idle: begin
                if (axis_hit) begin
                    // Start of read: newest sample shown, flag cleared
                    if (pend_vld) begin
                        next_shw_x = pend_x;                    // R4
                        next_shw_y = pend_y;
                        next_shw_z = pend_z;
                        next_pend_vld = 1'b0;
                    end
                    next_ready = 1'b0;                          // R2 R4
                    if (!last_hit) begin
                        next_state = asr_pkg::asr_reading;
                    end
                end
            end
            asr_pkg::asr_reading: begin
                // Bytes stay coherent: shown sample frozen until done
                if (last_hit) begin
                    next_state = asr_pkg::asr_idle;             // R6 R12
                end
            end
            default: begin
                next_state = asr_pkg::asr_idle;
            end
        endcase
        // Idle with nothing being read: a new sample shows at once
        if (new_valid) begin
            if (state == asr_pkg::asr_idle && !axis_hit) begin
                next_shw_x = sc_x;                              // R10
                next_shw_y = sc_y;
                next_shw_z = sc_z;
                next_pend_vld = 1'b0;
            end else begin
                // Older pending sample silently overwritten
                next_pend_x = sc_x;                             // R5
                next_pend_y = sc_y;
                next_pend_z = sc_z;
                next_pend_vld = 1'b1;
            end
            next_ready = 1'b1;                                  // R1 R3
        end
    end

    // Registers for sample state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= asr_pkg::asr_idle;
            pend_x   <= `ASR_RST_WORD;
            pend_y   <= `ASR_RST_WORD;
            pend_z   <= `ASR_RST_WORD;
            pend_vld <= 1'b0;
            shw_x    <= `ASR_RST_WORD;
            shw_y    <= `ASR_RST_WORD;
            shw_z    <= `ASR_RST_WORD;
            ready    <= 1'b0;
        end else begin
            state    <= next_state;
            pend_x   <= next_pend_x;
            pend_y   <= next_pend_y;
            pend_z   <= next_pend_z;
            pend_vld <= next_pend_vld;
            shw_x    <= next_shw_x;
            shw_y    <= next_shw_y;
            shw_z    <= next_shw_z;
            ready    <= next_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data mux and flag routing
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] next_rd_data;               // Next read data
    logic       next_serial_out;            // Next serial out level
    logic       next_irq0;                  // Next interrupt 0
    logic       next_irq1;                  // Next interrupt 1
    logic [15:0] rx, ry, rz;                // Sample the read returns

    // A read opening a session returns the newest sample directly
    always_comb begin
        rx = shw_x;
        ry = shw_y;
        rz = shw_z;
        if (state == asr_pkg::asr_idle && pend_vld) begin
            rx = pend_x;                                        // R4
            ry = pend_y;
            rz = pend_z;
        end
        next_rd_data = `ASR_RST_BYTE;
        if (rd_en) begin
            case (rd_addr)
                `ASR_OFS_STATUS: next_rd_data = {7'h00, ready};
                `ASR_OFS_XH: next_rd_data = rx[15:8];           // R10
                `ASR_OFS_XL: next_rd_data = rx[7:0];            // R10
                `ASR_OFS_YH: next_rd_data = ry[15:8];           // R10
                `ASR_OFS_YL: next_rd_data = ry[7:0];            // R10
                `ASR_OFS_ZH: next_rd_data = rz[15:8];           // R10
                `ASR_OFS_ZL: next_rd_data = rz[7:0];
                default: next_rd_data = `ASR_RST_BYTE;
            endcase
        end
        // Pin and interrupts registered from the next flag, so they change with the flag
        next_serial_out = ready_on_serial_out_select & next_ready; // R7
        next_irq0 = ready_to_irq0_map & next_ready;             // R8
        next_irq1 = ready_to_irq1_map & next_ready;             // R8
    end

    // Output registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data         <= `ASR_RST_BYTE;
            serial_out_pin  <= 1'b0;
            interrupt_out_0 <= 1'b0;
            interrupt_out_1 <= 1'b0;
        end else begin
            rd_data         <= next_rd_data;
            serial_out_pin  <= next_serial_out;
            interrupt_out_0 <= next_irq0;
            interrupt_out_1 <= next_irq1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////
    sequence s_new_sample;
        new_valid;
    endsequence

    sequence s_read_start;
        state == asr_pkg::asr_idle && axis_hit && !new_valid;
    endsequence

    a_flag_sets_on_sample: assert property ( // R1
        @(posedge sys_clk) disable iff (!rstn)
        s_new_sample |=> ready)
        else $error("flag not set after new sample");

    a_flag_clears_on_read: assert property ( // R2
        @(posedge sys_clk) disable iff (!rstn)
        s_read_start |=> !ready)
        else $error("flag not cleared at read start");

    a_flag_held_in_read: assert property ( // R3
        @(posedge sys_clk) disable iff (!rstn)
        (state == asr_pkg::asr_reading && ready) |=> ready)
        else $error("flag dropped during read");

    a_newest_supplied: assert property ( // R4
        @(posedge sys_clk) disable iff (!rstn)
        (state == asr_pkg::asr_idle && pend_vld && rd_en &&
         rd_addr == `ASR_OFS_XH) |=> rd_data == $past(pend_x[15:8]))
        else $error("newest sample not supplied");

    a_frozen_in_read: assert property ( // R12
        @(posedge sys_clk) disable iff (!rstn)
        (state == asr_pkg::asr_reading) |=> $stable(shw_x) || $past(last_hit))
        else $error("sample changed inside read");

    a_done_flag_low: assert property ( // R6
        @(posedge sys_clk) disable iff (!rstn)
        (s_read_start ##1 (!new_valid) [*2]) |=> !ready)
        else $error("flag not zero after read");

    a_serial_routed: assert property ( // R7
        @(posedge sys_clk) disable iff (!rstn)
        ready_on_serial_out_select ##1 ready_on_serial_out_select
        |-> serial_out_pin == ready)
        else $error("serial out not following flag");

    a_irq_routed: assert property ( // R8
        @(posedge sys_clk) disable iff (!rstn)
        ##1 (interrupt_out_0 == ($past(ready_to_irq0_map) & ready)) &&
        (interrupt_out_1 == ($past(ready_to_irq1_map) & ready)))
        else $error("interrupt not following map");

    a_lowres_mask: assert property ( // R9
        @(posedge sys_clk) disable iff (!rstn)
        (new_valid && low_res && state == asr_pkg::asr_idle && !axis_hit)
        |=> shw_y[3:0] == 4'h0)
        else $error("low bits not zero in low-res mode");
endmodule : asr_sample_ready

// [tb/asr_host_model.sv]
// Purpose: Host that reads the sample registers byte by byte
// Assumes: Read data is valid one cycle after the strobe edge
// Notes:   A released address shows the inverse of its last value
`timescale 1ns/1ps
module asr_host_model (
    input  wire logic       sys_clk,  // Bus clock
    output logic            rd_en,    // Read strobe
    output logic      [7:0] rd_addr,  // Read address
    input  wire logic [7:0] rd_data   // Registered read data
);
    initial begin
        rd_en   = 1'b0;
        rd_addr = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////
    // Back-to-back burst, strobe held until the last address is taken
    task automatic burst(input logic [7:0] a0, input int n,
                         output logic [7:0] q [6]);
        @(posedge sys_clk);
        rd_en   <= 1'b1;
        rd_addr <= a0;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            if (i + 1 < n) begin
                rd_addr <= a0 + 8'(i + 1);
            end else begin
                rd_en   <= 1'b0;
                rd_addr <= ~rd_addr;  // Stale address must not linger
            end
            #1 q[i] = rd_data;        // Let the edge's update land
        end
    endtask : burst
endmodule : asr_host_model

// [tb/test_asr_sample_ready.sv]
// Purpose: Self-checking bench for the sample ready register block
// Assumes: Fixed one-cycle read latency, host model does the reads
// Notes:   Pins are checked at least two edges after their cause
`timescale 1ns/1ps
module test_asr_sample_ready;
    logic               sys_clk;    // 200 MHz clock
    logic               rstn;       // Reset, active low
    logic               new_valid;  // Sample strobe
    logic        [15:0] new_x;      // Raw X
    logic        [15:0] new_y;      // Raw Y
    logic        [15:0] new_z;      // Raw Z
    asr_pkg::asr_mode_t power_mode; // Converter mode
    logic        [1:0]  range_sel;  // Range setting
    logic        [2:0]  route;      // Select, irq0 map, irq1 map
    logic               rd_en;      // From host model
    logic        [7:0]  rd_addr;    // From host model
    logic        [7:0]  rd_data;    // To host model
    logic        [2:0]  pins;       // Serial out, irq0, irq1
    logic        [15:0] w [3];      // Words of the last sample read
    logic        [7:0]  q [6];      // Bytes of the last burst
    int                 failures;   // Mismatches
    int                 checked;    // Comparisons

    asr_sample_ready uut (
        .sys_clk                    (sys_clk),
        .rstn                       (rstn),
        .new_valid                  (new_valid),
        .new_x                      (new_x),
        .new_y                      (new_y),
        .new_z                      (new_z),
        .power_mode                 (power_mode),
        .range_sel                  (range_sel),
        .rd_en                      (rd_en),
        .rd_addr                    (rd_addr),
        .ready_on_serial_out_select (route[2]),
        .ready_to_irq0_map          (route[1]),
        .ready_to_irq1_map          (route[0]),
        .rd_data                    (rd_data),
        .serial_out_pin             (pins[2]),
        .interrupt_out_0            (pins[1]),
        .interrupt_out_1            (pins[0])
    );
    asr_host_model host (
        .sys_clk (sys_clk),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One-cycle sample strobe
    task automatic push(input logic [15:0] x, y, z);
        @(posedge sys_clk);
        new_valid <= 1'b1;
        new_x     <= x;
        new_y     <= y;
        new_z     <= z;
        @(posedge sys_clk);
        new_valid <= 1'b0;
    endtask : push

    // Whole session, 0x15 to 0x1A, so it always closes
    task automatic read_axes();
        host.burst(8'h15, 6, q);
        for (int i = 0; i < 3; i++) begin
            w[i] = {q[2*i], q[2*i+1]};
        end
    endtask : read_axes

    task automatic axes_check(input logic [15:0] x, y, z);
        check("x word", w[0], x);
        check("y word", w[1], y);
        check("z word", w[2], z);
    endtask : axes_check

    // Pins change with the flag on the same edge; wait two edges before looking
    task automatic pins_check(input logic flag);
        repeat (2) @(posedge sys_clk);
        #1;
        check("pins", {13'h0000, pins}, {13'h0000, route & {3{flag}}});
    endtask : pins_check
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        host.burst(8'h13, 6, q);
        for (int i = 0; i < 6; i++) begin
            check("reset byte", {8'h00, q[i]}, 16'h0000);
        end
        host.burst(8'h19, 3, q);
        for (int i = 0; i < 3; i++) begin
            check("z or unmapped", {8'h00, q[i]}, 16'h0000);
        end
    endtask : t_reset

    // Every route pattern, flag set then cleared by a session
    task automatic t_route();
        for (int p = 0; p < 8; p++) begin
            @(posedge sys_clk);
            route <= 3'(p);
            push(16'hA5C3 ^ 16'(p), 16'h5A3C, 16'h8001);
            pins_check(1'b1);
            host.burst(8'h14, 1, q);
            check("status", {8'h00, q[0]}, 16'h0001);
            read_axes();
            axes_check(16'hA5C3 ^ 16'(p), 16'h5A3C, 16'h8001);
            pins_check(1'b0);
        end
    endtask : t_route

    // Newer sample lands while the old one is being read
    task automatic t_midread();
        push(16'h1357, 16'h2468, 16'h0F0F);
        read_axes();
        fork
            read_axes();
            begin
                repeat (3) @(posedge sys_clk);
                push(16'hFEDC, 16'hBA98, 16'h7654);
            end
        join
        axes_check(16'h1357, 16'h2468, 16'h0F0F);
        pins_check(1'b1);
        read_axes();
        axes_check(16'hFEDC, 16'hBA98, 16'h7654);
        pins_check(1'b0);
    endtask : t_midread

    task automatic t_overtake();
        push(16'h1111, 16'h2222, 16'h3333);
        push(16'h4444, 16'h5555, 16'h6666);
        pins_check(1'b1);
        read_axes();
        axes_check(16'h4444, 16'h5555, 16'h6666);
        pins_check(1'b0);
    endtask : t_overtake

    task automatic t_modes();
        logic [15:0] msk;  // Low nibble cleared in 12-bit modes
        for (int m = 0; m < 5; m++) begin
            @(posedge sys_clk);
            power_mode <= asr_pkg::asr_mode_t'(m);
            push(16'h1235, 16'h8ACF, 16'h7FF9);
            read_axes();
            msk = (m >= 2) ? 16'hFFF0 : 16'hFFFF;
            axes_check(16'h1235 & msk, 16'h8ACF & msk, 16'h7FF9 & msk);
        end
    endtask : t_modes

    task automatic t_range();
        int sh;  // Arithmetic shift per range setting
        for (int r = 0; r < 4; r++) begin
            @(posedge sys_clk);
            power_mode <= asr_pkg::asr_mode_high_perf;
            range_sel  <= 2'(r);
            push(16'h8100, 16'h0104, 16'h7FFC);
            read_axes();
            sh = (r == 3) ? 0 : r;
            axes_check(16'($signed(16'h8100) >>> sh),
                       16'($signed(16'h0104) >>> sh),
                       16'($signed(16'h7FFC) >>> sh));
        end
    endtask : t_range

    // Reset in mid-run drops the shown sample and the flag
    task automatic t_rerun_reset();
        push(16'h4242, 16'h2424, 16'h1818);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        pins_check(1'b0);
        read_axes();
        axes_check(16'h0000, 16'h0000, 16'h0000);
    endtask : t_rerun_reset

    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk    = 1'b0;
        rstn       = 1'b0;
        new_valid  = 1'b0;
        new_x      = 16'h0000;
        new_y      = 16'h0000;
        new_z      = 16'h0000;
        power_mode = asr_pkg::asr_mode_high_perf;
        range_sel  = 2'h0;
        route      = 3'h0;
        failures   = 0;
        checked    = 0;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_route();
        t_midread();
        t_overtake();
        t_modes();
        t_range();
        t_rerun_reset();
        results();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("BAD watchdog expected finish seen hang");
        results();
    end
endmodule : test_asr_sample_ready
